// File: lpms_pkg.sv
// Package of constants and types for the low-power mode sequencer
package lpms_pkg;

  // Width of the shared wait counter (lock wait needs 18 bits)
  localparam int unsigned CNT_W              = 18;
  // Width of the standby wake qualifier counter
  localparam int unsigned QCNT_W             = 7;
  // Width of the standby qualify count field
  localparam int unsigned QUAL_W             = 6;

  // Cycles the system clock is held after the idle instruction
  localparam logic [CNT_W-1:0] FLUSH_CYC     = 18'h00020;  // 32 cycles
  // Latest cycle at which the clock out pin must be low
  localparam logic [CNT_W-1:0] CLKOUT_MAX_CYC = 18'h0002D; // 45 cycles

  // Standby resume limits, wake to execution, in system cycles
  localparam logic [CNT_W-1:0] STBY_FAST_MAX_CYC = 18'h00064; // 100 cycles
  localparam logic [CNT_W-1:0] STBY_SLOW_MAX_CYC = 18'h00465; // 1125 cycles
  // Cycles already spent by synchroniser, qualifier and hand-over
  localparam logic [CNT_W-1:0] STBY_OVH_CYC      = 18'h00008;
  // Resume delays actually counted after a qualified standby wake
  localparam logic [CNT_W-1:0] STBY_FAST_DLY_CYC = STBY_FAST_MAX_CYC - STBY_OVH_CYC;
  localparam logic [CNT_W-1:0] STBY_SLOW_DLY_CYC = STBY_SLOW_MAX_CYC - STBY_OVH_CYC;

  // Halt resume limits, lock to execution, in system cycles
  localparam logic [CNT_W-1:0] HALT_FAST_MAX_CYC = 18'h00023; // 35 cycles
  localparam logic [CNT_W-1:0] HALT_SLOW_MAX_CYC = 18'h00465; // 1125 cycles
  // Cycles spent in hand-over from lock to resume
  localparam logic [CNT_W-1:0] HALT_OVH_CYC      = 18'h00002;
  localparam logic [CNT_W-1:0] HALT_FAST_DLY_CYC = HALT_FAST_MAX_CYC - HALT_OVH_CYC;
  localparam logic [CNT_W-1:0] HALT_SLOW_DLY_CYC = HALT_SLOW_MAX_CYC - HALT_OVH_CYC;

  // PLL lock wait in oscillator cycles
  localparam int unsigned LOCK_CYC           = 131072;

  // Least unqualified standby wake pulse, oscillator cycles
  localparam logic [QCNT_W-1:0] WAKE_UNQ_CYC = 7'h03;
  // Fixed part of the qualified standby wake pulse
  localparam logic [QCNT_W-1:0] WAKE_QUAL_BASE = 7'h02;

  // Sequencer states
  typedef enum logic [2:0] {
    LPMS_RUN,        // Normal execution
    LPMS_FLUSH,      // Pipeline drain after idle
    LPMS_STBY,       // Standby, waiting for wake
    LPMS_STBY_RES,   // Standby resume latency
    LPMS_HALT,       // Halt, everything stopped except the oscillator without crystal source
    LPMS_OSC_WAIT,   // Oscillator starting, wake still held
    LPMS_LOCK,       // PLL lock wait
    LPMS_HALT_RES    // Halt resume latency
  } lpms_state_t;

endpackage : lpms_pkg

// File: lpms_wake_if.sv
// Interface carrying the synchronised wake inputs
interface lpms_wake_if;
  logic gpio_s;    // Wake GPIO pin, synchronised, high = idle
  logic stby_s;    // Standby wake signal, synchronised, high = idle
  logic xrst_s;    // External reset pin, synchronised, high = idle

  // Producer side: the synchroniser
  modport sync_mp (output gpio_s, output stby_s, output xrst_s);
  // Consumer side: the sequencer
  modport seq_mp  (input gpio_s, input stby_s, input xrst_s);
endinterface : lpms_wake_if

// File: lpms_wake_sync.sv
// Two-stage synchroniser for the asynchronous wake pins
module lpms_wake_sync (
  input  wire logic  i_clk,        // System clock
  input  wire logic  i_rst_b,      // Released reset copy
  input  wire logic  i_ce,         // Clock enable
  input  wire logic  i_gpio_b,     // Raw wake GPIO pin
  input  wire logic  i_stby_b,     // Raw standby wake pin
  input  wire logic  i_xrst_b,     // Raw external reset pin
  lpms_wake_if.sync_mp wake        // Synchronised outputs
);
  import lpms_pkg::*;

  logic [2:0] meta_q;   // First stage, read only by second stage
  logic [2:0] sync_q;   // Second stage, safe to use
  logic [2:0] meta_d;   // Next first stage
  logic [2:0] sync_d;   // Next second stage

  // Next values, frozen while clock enable is low
  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (i_ce) begin
      meta_d = {i_xrst_b, i_stby_b, i_gpio_b};
      sync_d = meta_q;
    end
  end

  // Registers; pins idle high so reset to ones
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  // Hand the stable copies over
  assign wake.gpio_s = sync_q[0];
  assign wake.stby_s = sync_q[1];
  assign wake.xrst_s = sync_q[2];

endmodule : lpms_wake_sync

// File: lpms_seq.sv
// Low-power mode sequencer: standby and halt entry and exit
// Behaviour
// - Clock out low 32 to 45 cycles after idle
// - Standby: hold system clock 32 cycles, then stop
// - Standby gates peripherals, keeps PLL and watchdog
// - Standby resume within 100 or 1125 cycles
// - Resume at instruction after idle; interrupt later
// - Halt: hold 32 cycles, stop crystal oscillator, core clock
// - Halt stops peripherals, PLL, crystal oscillator
// - Wake pin falling edge restarts oscillator in halt
// - Wake pin release starts 131072-cycle PLL lock
// - Halt resume within 1125 or 35 cycles after lock
// - Core clock back: leave halt, service wake interrupt
module lpms_seq #(
  parameter int unsigned P_LOCK_CYC = lpms_pkg::LOCK_CYC  // PLL lock wait, cycles
) (
  input  wire logic                       i_sys_clk,        // System clock, 20 MHz
  input  wire logic                       i_rst_b,          // Asynchronous reset, active low
  input  wire logic                       i_clk_en,         // Clock enable, freezes sequencer and wake synchroniser state, clears pulses
  input  wire logic                       i_idle_exec,      // Idle instruction executed, pulse
  input  wire logic                       i_mode_halt,      // Mode select: 1 halt, 0 standby
  input  wire logic                       i_qual_en,        // Standby wake qualification on
  input  wire logic [lpms_pkg::QUAL_W-1:0] i_stby_qual_cnt, // Standby qualify count
  input  wire logic                       i_flash_sleep,    // Flash asleep during low power
  input  wire logic                       i_xtal_src,       // Crystal or resonator is the source
  input  wire logic                       i_wake_int_en,    // Wake interrupt enabled
  input  wire logic                       i_wake_gpio_pin_b, // Wake GPIO pin, active low
  input  wire logic                       i_stby_wake_b,    // Standby wake signal, active low
  input  wire logic                       i_ext_reset_pin_b, // External reset pin, active low
  output logic                            o_clock_out_pin,  // Clock out pin enable
  output logic                            o_sys_clk_en,     // System clock running
  output logic                            o_periph_clk_en,  // Peripheral clocks running
  output logic                            o_pll_en,         // PLL powered
  output logic                            o_osc_en,         // Internal oscillator powered
  output logic                            o_wdog_clk_en,    // Watchdog clock running
  output logic                            o_core_clk_en,    // Core clock input enabled
  output logic                            o_standby,        // In standby mode
  output logic                            o_halt,           // In halt mode
  output logic                            o_resume,         // Execution resumes, pulse
  output logic                            o_wake_irq        // Wake interrupt request, pulse
);
  import lpms_pkg::*;

  // Last count of the lock wait, at counter width
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(P_LOCK_CYC - 1);

  // Reset release synchroniser
  logic rst_meta_q;     // First stage, read only by second
  logic rst_sync_q;     // Released reset used by the design

  // Release reset through two flip-flops
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Synchronised wake inputs
  lpms_wake_if wake ();

  // Asynchronous wake pins pass two flops before any use
  lpms_wake_sync u_sync (
    .i_clk    (i_sys_clk),
    .i_rst_b  (rst_sync_q),
    .i_ce     (i_clk_en),
    .i_gpio_b (i_wake_gpio_pin_b),
    .i_stby_b (i_stby_wake_b),
    .i_xrst_b (i_ext_reset_pin_b),
    .wake     (wake.sync_mp)
  );

  // Sequencer state
  lpms_state_t      state_q;     // Current state
  lpms_state_t      state_d;     // Next state
  logic [CNT_W-1:0] cnt_q;       // Shared wait counter
  logic [CNT_W-1:0] cnt_d;       // Next counter value
  logic [QCNT_W-1:0] qcnt_q;     // Consecutive low samples of standby wake
  logic [QCNT_W-1:0] qcnt_d;     // Next qualifier count
  logic             gpio_prev_q; // Previous synchronised wake pin
  logic             gpio_prev_d; // Next previous value
  logic             halt_sel_q;  // Mode latched at idle
  logic             halt_sel_d;  // Next latched mode

  // Registered outputs and their next values
  logic clkout_q,  clkout_d;     // Clock out pin enable
  logic sysclk_q,  sysclk_d;     // System clock enable
  logic periph_q,  periph_d;     // Peripheral clock enable
  logic pll_q,     pll_d;        // PLL enable
  logic osc_q,     osc_d;        // Oscillator enable
  logic wdog_q,    wdog_d;       // Watchdog clock enable
  logic core_q,    core_d;       // Core clock input enable
  logic resume_q,  resume_d;     // Resume pulse
  logic irq_q,     irq_d;        // Wake interrupt pulse

  // Derived helpers
  logic [QCNT_W-1:0] wake_thr;   // Required low samples for standby wake
  logic [CNT_W-1:0]  stby_dly;   // Standby resume delay
  logic [CNT_W-1:0]  halt_dly;   // Halt resume delay
  logic              gpio_fall;  // Falling edge of wake pin
  logic              stby_hit;   // Standby wake qualified this cycle

  // Wake thresholds, delays and edge detect
  always_comb begin
    // Pulse width needed: 3 unqualified, else 2 plus count
    wake_thr  = i_qual_en ? (WAKE_QUAL_BASE + QCNT_W'(i_stby_qual_cnt))
                          : WAKE_UNQ_CYC;
    // Resume latency budget by memory in use
    stby_dly  = i_flash_sleep ? STBY_SLOW_DLY_CYC : STBY_FAST_DLY_CYC;
    halt_dly  = i_flash_sleep ? HALT_SLOW_DLY_CYC : HALT_FAST_DLY_CYC;
    // Edge seen on the synchronised copy only
    gpio_fall = gpio_prev_q & ~wake.gpio_s;
    // Wake accepted once the pin stayed low long enough
    stby_hit  = ~wake.stby_s & (qcnt_q == (wake_thr - 7'h01));
  end

  // Next-state logic for the sequencer
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    qcnt_d      = qcnt_q;
    halt_sel_d  = halt_sel_q;
    gpio_prev_d = gpio_prev_q;
    clkout_d    = clkout_q;
    sysclk_d    = sysclk_q;
    periph_d    = periph_q;
    pll_d       = pll_q;
    osc_d       = osc_q;
    wdog_d      = wdog_q;
    core_d      = core_q;
    resume_d    = 1'b0;
    irq_d       = 1'b0;
    if (i_clk_en) begin
      gpio_prev_d = wake.gpio_s;
      case (state_q)
        // Running: wait for the idle instruction
        LPMS_RUN: begin
          qcnt_d = '0;
          if (i_idle_exec) begin
            halt_sel_d = i_mode_halt;
            cnt_d      = '0;
            state_d    = LPMS_FLUSH;
          end
        end
        // Drain pipeline with system clock still running
        LPMS_FLUSH: begin
          cnt_d = cnt_q + 18'h00001;
          if (cnt_q == FLUSH_CYC - 18'h00001) begin
            // Clock out falls 32 cycles after idle
            clkout_d = 1'b0;
            sysclk_d = 1'b0;
            periph_d = 1'b0;
            cnt_d    = '0;
            if (halt_sel_q) begin
              // Halt: core clock, PLL and watchdog stop
              core_d  = 1'b0;
              pll_d   = 1'b0;
              wdog_d  = 1'b0;
              // Oscillator stops only with crystal as source, else keeps its state
              osc_d   = ~i_xtal_src ? osc_q : 1'b0;
              state_d = LPMS_HALT;
            end else begin
              // Standby: PLL and watchdog keep running
              pll_d   = 1'b1;
              wdog_d  = 1'b1;
              qcnt_d  = '0;
              state_d = LPMS_STBY;
            end
          end
        end
        // Standby: qualify the wake pulse
        LPMS_STBY: begin
          if (wake.stby_s) begin
            qcnt_d = '0;
          end else if (qcnt_q != 7'h7F) begin
            qcnt_d = qcnt_q + 7'h01;
          end
          if (stby_hit) begin
            // Clocks back, then count the resume latency
            clkout_d = 1'b1;
            sysclk_d = 1'b1;
            periph_d = 1'b1;
            cnt_d    = '0;
            state_d  = LPMS_STBY_RES;
          end
        end
        // Standby resume latency
        LPMS_STBY_RES: begin
          cnt_d = cnt_q + 18'h00001;
          if (cnt_q == stby_dly - 18'h00001) begin
            // Next instruction after idle executes now
            resume_d = 1'b1;
            irq_d    = i_wake_int_en;
            state_d  = LPMS_RUN;
          end
        end
        // Halt: wait for wake pin fall or reset pin low
        LPMS_HALT: begin
          if (gpio_fall || !wake.xrst_s) begin
            osc_d   = 1'b1;
            state_d = LPMS_OSC_WAIT;
          end
        end
        // Oscillator stabilising while waker holds pin low
        LPMS_OSC_WAIT: begin
          // Waker keeps pins low past oscillator start
          if (wake.gpio_s && wake.xrst_s) begin
            pll_d   = 1'b1;
            cnt_d   = '0;
            state_d = LPMS_LOCK;
          end
        end
        // PLL lock wait after pin release
        LPMS_LOCK: begin
          cnt_d = cnt_q + 18'h00001;
          if (cnt_q == LOCK_LAST) begin
            // Core clock input re-enabled, halt left
            core_d   = 1'b1;
            sysclk_d = 1'b1;
            clkout_d = 1'b1;
            periph_d = 1'b1;
            wdog_d   = 1'b1;
            cnt_d    = '0;
            state_d  = LPMS_HALT_RES;
          end
        end
        // Halt resume latency after lock
        LPMS_HALT_RES: begin
          cnt_d = cnt_q + 18'h00001;
          if (cnt_q == halt_dly - 18'h00001) begin
            resume_d = 1'b1;
            irq_d    = i_wake_int_en;
            state_d  = LPMS_RUN;
          end
        end
        // Unknown state: recover to running
        default: begin
          state_d = LPMS_RUN;
          cnt_d   = '0;
        end
      endcase
    end
  end

  // Register all sequencer state and outputs except the mode flags
  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q     <= LPMS_RUN;
      cnt_q       <= '0;
      qcnt_q      <= '0;
      halt_sel_q  <= 1'b0;
      gpio_prev_q <= 1'b1;
      clkout_q    <= 1'b1;
      sysclk_q    <= 1'b1;
      periph_q    <= 1'b1;
      pll_q       <= 1'b1;
      osc_q       <= 1'b1;
      wdog_q      <= 1'b1;
      core_q      <= 1'b1;
      resume_q    <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      qcnt_q      <= qcnt_d;
      halt_sel_q  <= halt_sel_d;
      gpio_prev_q <= gpio_prev_d;
      clkout_q    <= clkout_d;
      sysclk_q    <= sysclk_d;
      periph_q    <= periph_d;
      pll_q       <= pll_d;
      osc_q       <= osc_d;
      wdog_q      <= wdog_d;
      core_q      <= core_d;
      resume_q    <= resume_d;
      irq_q       <= irq_d;
    end
  end

  // Mode flags registered from next state
  logic stby_flag_q;   // Standby indication
  logic halt_flag_q;   // Halt indication
  logic stby_flag_d;   // Next standby indication
  logic halt_flag_d;   // Next halt indication

  // Mode flags follow the next state
  always_comb begin
    stby_flag_d = (state_d == LPMS_STBY);
    halt_flag_d = (state_d == LPMS_HALT) || (state_d == LPMS_OSC_WAIT) || (state_d == LPMS_LOCK);
  end

  // Mode flag registers
  always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      stby_flag_q <= 1'b0;
      halt_flag_q <= 1'b0;
    end else begin
      stby_flag_q <= stby_flag_d;
      halt_flag_q <= halt_flag_d;
    end
  end

  // Outputs straight from flops
  assign o_clock_out_pin = clkout_q;
  assign o_sys_clk_en    = sysclk_q;
  assign o_periph_clk_en = periph_q;
  assign o_pll_en        = pll_q;
  assign o_osc_en        = osc_q;
  assign o_wdog_clk_en   = wdog_q;
  assign o_core_clk_en   = core_q;
  assign o_standby       = stby_flag_q;
  assign o_halt          = halt_flag_q;
  assign o_resume        = resume_q;
  assign o_wake_irq      = irq_q;

endmodule : lpms_seq

// File: lpms_waker.sv
// Wake source model driving the sequencer's three active-low wake pins
module lpms_waker (
  input  wire logic i_sys_clk,          // System clock
  output logic      o_wake_gpio_pin_b,  // Wake GPIO pin, pulled up when idle
  output logic      o_stby_wake_b,      // Standby wake line, pulled up when idle
  output logic      o_ext_reset_pin_b   // External reset pin, pulled up when idle
);
  timeunit 1ns;
  timeprecision 1ps;
  // All pins rest at the pull-up level
  initial begin
    o_wake_gpio_pin_b = 1'b1;
    o_stby_wake_b     = 1'b1;
    o_ext_reset_pin_b = 1'b1;
  end
  // Low pulse of len cycles on one pin: 0 GPIO, 1 standby, 2 reset
  task automatic pulse(input int sel, input int len);
    @(negedge i_sys_clk);
    case (sel)
      0: o_wake_gpio_pin_b = 1'b0;
      1: o_stby_wake_b = 1'b0;
      default: o_ext_reset_pin_b = 1'b0;
    endcase
    repeat (len) @(negedge i_sys_clk); // Hold past oscillator start
    o_wake_gpio_pin_b = 1'b1;
    o_stby_wake_b     = 1'b1;
    o_ext_reset_pin_b = 1'b1;
  endtask : pulse
endmodule : lpms_waker

// File: lpms_asserts.sv
// Port-level checker for the low-power mode sequencer
module lpms_asserts #(
  parameter int unsigned P_LOCK_CYC = 16  // PLL lock wait, cycles
) (
  input wire logic i_sys_clk,         // System clock
  input wire logic i_rst_b,           // Reset, active low
  input wire logic i_idle_exec,       // Idle pulse
  input wire logic i_clk_en,          // Clock enable
  input wire logic i_xtal_src,        // Crystal source
  input wire logic i_flash_sleep,     // Flash asleep
  input wire logic i_wake_int_en,     // Wake interrupt enable
  input wire logic i_wake_gpio_pin_b, // Wake GPIO pin
  input wire logic o_clock_out_pin,   // Clock out enable
  input wire logic o_sys_clk_en,      // System clock on
  input wire logic o_periph_clk_en,   // Peripheral clocks on
  input wire logic o_pll_en,          // PLL on
  input wire logic o_osc_en,          // Oscillator on
  input wire logic o_wdog_clk_en,     // Watchdog clock on
  input wire logic o_core_clk_en,     // Core clock on
  input wire logic o_standby,         // Standby flag
  input wire logic o_halt,            // Halt flag
  input wire logic o_resume,          // Resume pulse
  input wire logic o_wake_irq         // Wake interrupt pulse
);
  import lpms_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic [31:0] lk_cnt_q; // Cycles spent locking
  logic [31:0] lk_cnt_d; // Next lock count
  logic        sb_prev_q; // Standby flag one cycle ago
  logic        hl_prev_q; // Halt flag one cycle ago
  logic [10:0] rs_cnt_q;  // Cycles since a mode was left, resume pending
  logic [10:0] rs_cnt_d;  // Next resume wait count
  logic        rs_halt_q; // Pending resume comes from halt
  logic        rs_halt_d; // Next origin of the pending resume
  // Count resume latency from mode exit; long waits need a counter
  always_comb begin
    rs_cnt_d  = rs_cnt_q;
    rs_halt_d = rs_halt_q;
    if (sb_prev_q && !o_standby) begin
      rs_cnt_d  = 11'h001;
      rs_halt_d = 1'b0;
    end else if (hl_prev_q && !o_halt) begin
      rs_cnt_d  = 11'h001;
      rs_halt_d = 1'b1;
    end else if (o_resume) begin
      rs_cnt_d  = 11'h000;
    end else if (rs_cnt_q != 11'h000 && rs_cnt_q != 11'h7FF) begin
      rs_cnt_d  = rs_cnt_q + 11'h001;
    end
  end
  // Count lock cycles, clear outside halt
  always_comb begin
    lk_cnt_d = lk_cnt_q;
    if (o_halt && o_pll_en && !o_core_clk_en) begin
      lk_cnt_d = lk_cnt_q + 32'h1;
    end else if (!o_halt) begin
      lk_cnt_d = 32'h0;
    end
  end
  // Register the lock count and resume wait helpers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lk_cnt_q  <= 32'h0;
      sb_prev_q <= 1'b0;
      hl_prev_q <= 1'b0;
      rs_cnt_q  <= 11'h000;
      rs_halt_q <= 1'b0;
    end else begin
      lk_cnt_q  <= lk_cnt_d;
      sb_prev_q <= o_standby;
      hl_prev_q <= o_halt;
      rs_cnt_q  <= rs_cnt_d;
      rs_halt_q <= rs_halt_d;
    end
  end
  idle_clkout_a: assert property (i_idle_exec && i_clk_en && o_sys_clk_en && !o_standby && !o_halt
    |-> (o_clock_out_pin throughout ##31 1'b1) ##[1:14] !o_clock_out_pin) else $error("clock out fall off");
  stby_stop_a: assert property ($rose(o_standby) |-> !o_sys_clk_en && !o_clock_out_pin)
    else $error("standby clock not stopped");
  stby_keep_a: assert property (o_standby |-> o_pll_en && o_wdog_clk_en && !o_periph_clk_en)
    else $error("standby clock set wrong");
  stby_fast_a: assert property ($fell(o_standby) && !i_flash_sleep |-> ##[1:100] o_resume)
    else $error("standby resume late");
  stby_slow_a: assert property (rs_cnt_q != 11'h000 && !rs_halt_q && i_flash_sleep |-> rs_cnt_q <= 11'h465)
    else $error("standby slow resume late");
  irq_pair_a: assert property (o_resume || o_wake_irq |-> o_wake_irq == (o_resume && i_wake_int_en))
    else $error("wake interrupt mismatch");
  halt_stop_a: assert property ($rose(o_halt) |-> !o_sys_clk_en && !o_core_clk_en && !o_pll_en
    && !o_periph_clk_en && (o_osc_en == !i_xtal_src)) else $error("halt clocks wrong");
  osc_wake_a: assert property (o_halt && !o_osc_en && $fell(i_wake_gpio_pin_b) |-> ##[1:5] o_osc_en)
    else $error("oscillator not restarted");
  lock_hold_a: assert property (o_halt && !o_pll_en && !i_wake_gpio_pin_b |=> !o_pll_en)
    else $error("lock began under held pin");
  lock_len_a: assert property ($rose(o_core_clk_en) && $past(o_halt)
    |-> lk_cnt_q >= P_LOCK_CYC && lk_cnt_q <= P_LOCK_CYC + 2) else $error("lock length wrong");
  halt_fast_a: assert property ($fell(o_halt) && !i_flash_sleep |-> ##[1:35] o_resume)
    else $error("halt resume late");
  halt_slow_a: assert property (rs_cnt_q != 11'h000 && rs_halt_q && i_flash_sleep |-> rs_cnt_q <= 11'h465)
    else $error("halt slow resume late");
  halt_exit_a: assert property ($fell(o_halt) |-> o_core_clk_en && o_sys_clk_en && o_periph_clk_en)
    else $error("halt exit clocks off");
endmodule : lpms_asserts
bind lpms_seq lpms_asserts #(.P_LOCK_CYC(P_LOCK_CYC)) u_chk (.i_sys_clk, .i_rst_b, .i_idle_exec, .i_clk_en,
  .i_xtal_src, .i_flash_sleep, .i_wake_int_en, .i_wake_gpio_pin_b, .o_clock_out_pin, .o_sys_clk_en,
  .o_periph_clk_en, .o_pll_en, .o_osc_en, .o_wdog_clk_en, .o_core_clk_en, .o_standby, .o_halt, .o_resume,
  .o_wake_irq);

// File: lpms_tb.sv
// Self-checking testbench for the low-power mode sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lpms_pkg::*;
  localparam int LOCK = 16; // Short lock wait for simulation
  typedef struct {logic irq; int start; int lim;} lpms_note_t;
  logic i_sys_clk, i_rst_b, i_clk_en, i_idle_exec, i_mode_halt, i_qual_en;
  logic [QUAL_W-1:0] i_stby_qual_cnt;
  logic i_flash_sleep, i_xtal_src, i_wake_int_en;
  logic i_wake_gpio_pin_b, i_stby_wake_b, i_ext_reset_pin_b;
  logic o_clock_out_pin, o_sys_clk_en, o_periph_clk_en, o_pll_en, o_osc_en, o_wdog_clk_en;
  logic o_core_clk_en, o_standby, o_halt, o_resume, o_wake_irq;
  lpms_note_t notes[$]; // Expected resumes
  lpms_note_t nt;       // Note being compared
  int errors, checks_done, cyc, seed_val;
  lpms_seq #(.P_LOCK_CYC(LOCK)) DUT (.i_sys_clk, .i_rst_b, .i_clk_en, .i_idle_exec, .i_mode_halt, .i_qual_en,
    .i_stby_qual_cnt, .i_flash_sleep, .i_xtal_src, .i_wake_int_en, .i_wake_gpio_pin_b, .i_stby_wake_b,
    .i_ext_reset_pin_b, .o_clock_out_pin, .o_sys_clk_en, .o_periph_clk_en, .o_pll_en, .o_osc_en,
    .o_wdog_clk_en, .o_core_clk_en, .o_standby, .o_halt, .o_resume, .o_wake_irq);
  lpms_waker WAKER (.i_sys_clk, .o_wake_gpio_pin_b(i_wake_gpio_pin_b), .o_stby_wake_b(i_stby_wake_b),
    .o_ext_reset_pin_b(i_ext_reset_pin_b));
  // 20 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // Cycle counter
  always @(posedge i_sys_clk) cyc <= cyc + 1;
  // Verdict and end of run
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // Bounded wait: 0 standby, 1 halt, 2 clock out low, 3 notes drained
  task automatic wait_for(input int which, input int lim);
    int n;
    n = 0;
    while (n < lim && !((which == 0 && o_standby === 1'b1) || (which == 1 && o_halt === 1'b1)
        || (which == 2 && o_clock_out_pin === 1'b0) || (which == 3 && notes.size() == 0))) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      check(32'hFFFF_FFFF, which);
      wrap_up();
    end
  endtask : wait_for
  // Resume watcher takes the oldest note
  always @(posedge i_sys_clk) begin
    if (o_resume === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        check(o_wake_irq, nt.irq);
        check(cyc - nt.start <= nt.lim, 32'h1);
      end
    end
  end
  // One low-power cycle: k0 standby, k1 qualified standby, k2 halt by GPIO, k3 halt by reset pin
  task automatic run_case(input int k);
    int t0, len, d;
    @(negedge i_sys_clk);
    i_mode_halt = k[1];
    i_qual_en = (k == 1);
    i_stby_qual_cnt = QUAL_W'($urandom % 64);
    i_flash_sleep = k[0];
    i_xtal_src = (k != 3);
    i_wake_int_en = ~k[0];
    i_idle_exec = 1'b1;
    t0 = cyc;
    @(negedge i_sys_clk);
    i_idle_exec = 1'b0;
    wait_for(2, 60);
    d = cyc - t0 - 1;
    check(d >= 32 && d <= 45, 32'h1);
    wait_for(k[1], 10);
    if (k < 2) begin
      check({o_sys_clk_en, o_periph_clk_en, o_pll_en, o_wdog_clk_en}, 32'h3);
      if (k == 0) begin
        WAKER.pulse(1, 2);
        @(negedge i_sys_clk);
        i_clk_en = 1'b0;
        WAKER.pulse(1, 3);
        @(negedge i_sys_clk);
        i_clk_en = 1'b1;
        repeat (12) @(posedge i_sys_clk);
        check(o_standby, 32'h1);
      end
      len = (k == 1) ? 2 + i_stby_qual_cnt : 3;
      notes.push_back('{~k[0], cyc, (k[0] ? 1125 : 100) + len + 2});
      WAKER.pulse(1, len);
    end else begin
      check({o_sys_clk_en, o_periph_clk_en, o_pll_en, o_core_clk_en, o_osc_en}, !i_xtal_src);
      len = (k == 2) ? 6 + $urandom % 8 : 12 + $urandom % 8;
      notes.push_back('{~k[0], cyc, len + 3 + LOCK + (k[0] ? 1125 : 35) + 4});
      WAKER.pulse((k == 2) ? 0 : 2, len);
    end
    wait_for(3, 1400);
    check({o_clock_out_pin, o_sys_clk_en, o_periph_clk_en, o_pll_en, o_core_clk_en, o_standby, o_halt}, 32'h7C);
  endtask : run_case
  // Main sequence
  initial begin
    cyc = 0;
    errors = 0;
    checks_done = 0;
    i_rst_b = 1'b0;
    i_clk_en = 1'b1;
    i_idle_exec = 1'b0;
    i_mode_halt = 1'b0;
    i_qual_en = 1'b0;
    i_stby_qual_cnt = '0;
    i_flash_sleep = 1'b0;
    i_xtal_src = 1'b1;
    i_wake_int_en = 1'b1;
    seed_val = $urandom(32'h63D4);
    repeat (5) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    check({o_clock_out_pin, o_sys_clk_en, o_periph_clk_en, o_pll_en, o_osc_en, o_core_clk_en, o_halt}, 32'h7E);
    for (int k = 0; k < 4; k++) run_case(k);
    repeat (4) @(negedge i_sys_clk);
    wrap_up();
  end
endmodule : tb_top
